// file: inc/gst_pkg.sv
// Shared constants for the gated sixteen-bit timer control block.
package gst_pkg;
   // ==========================================================
   // Register byte addresses on the bus.
   localparam logic [7:0] GST_OFF_TIMER_CONTROL = 8'h00; // Clock, prescale, sync and on bits.
   localparam logic [7:0] GST_OFF_GATE_CONTROL = 8'h04; // Gate configuration and status.
   localparam logic [7:0] GST_OFF_COUNT_LOW = 8'h08; // Low byte of the count.
   localparam logic [7:0] GST_OFF_COUNT_HIGH = 8'h0c; // High byte of the count.
   localparam logic [7:0] GST_OFF_EVENT_FLAGS = 8'h10; // Sticky event flags, write one to clear.
   // ==========================================================
   // Field positions in the timer control register.
   localparam int GST_TC_CS_LO = 6; // Clock source select, bits 7:6.
   localparam int GST_TC_PS_LO = 4; // Prescale select, bits 5:4.
   localparam int GST_TC_SYNC_BYPASS = 2; // Sync bypass bit.
   localparam int GST_TC_TIMER_ON = 0; // Timer on bit.
   // ==========================================================
   // Field positions in the gate control register.
   localparam int GST_GC_GATE_ENABLE = 7; // Gate enable bit.
   localparam int GST_GC_POLARITY = 6; // Gate polarity bit.
   localparam int GST_GC_TOGGLE = 5; // Gate toggle mode bit.
   localparam int GST_GC_SINGLE_PULSE = 4; // Single pulse mode bit.
   localparam int GST_GC_ARMED = 3; // Single pulse armed bit.
   localparam int GST_GC_LEVEL = 2; // Gate level status bit.
   localparam int GST_GC_SS_LO = 0; // Gate source select, bits 1:0.
   // ==========================================================
   // Field positions in the event flag register.
   localparam int GST_EF_ROLLOVER = 0; // Rollover flag bit.
   localparam int GST_EF_GATE_EVENT = 1; // Gate event flag bit.
   // ==========================================================
   // Values after a power-on or brown-out reset.
   localparam logic [7:0] GST_RST_BYTE = 8'h00; // All control bytes clear.
   localparam logic [15:0] GST_RST_COUNT = 16'h0000; // Count value after reset.
   localparam logic [15:0] GST_COUNT_MAX = 16'hffff; // Last count before wrap.
   // ==========================================================
   // Clock source and gate source codes.
   localparam logic [1:0] GST_CS_FOSC_DIV4 = 2'h0; // System clock divided by four.
   localparam logic [1:0] GST_CS_FOSC = 2'h1; // System clock.
   localparam logic [1:0] GST_CS_EXT_PIN = 2'h2; // External clock pin.
   localparam logic [1:0] GST_CS_LFOSC = 2'h3; // Low-frequency internal oscillator.
   localparam logic [1:0] GST_GS_PIN = 2'h0; // Gate pin.
   localparam logic [1:0] GST_GS_TIMER0 = 2'h1; // Timer0 rollover pulse.
   localparam logic [1:0] GST_GS_COMP1 = 2'h2; // Comparator 1 output.
   localparam logic [1:0] GST_GS_COMP2 = 2'h3; // Comparator 2 output.
   // ==========================================================
   // Cycle counts.
   localparam logic [1:0] GST_DIV4_LAST = 2'h3; // Last phase of the divide-by-four counter.
   localparam int GST_SYNC_STAGES = 2; // Synchroniser depth for the external clock.
   // ==========================================================
   // Single pulse window states.
   typedef enum logic [0:0] {
      GST_SP_CLOSED = 1'b0,
      GST_SP_OPEN = 1'b1
   } gst_sp_state_t;
endpackage

// file: rtl/gst_edge_sync.sv
// Synchroniser with optional bypass and a registered rising-edge pulse.
`timescale 1ns/1ps
module gst_edge_sync
   import gst_pkg::*;
#(
   parameter int STAGES = GST_SYNC_STAGES
) (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_clock_en,
   input wire logic i_level,
   input wire logic i_bypass,
   output logic o_rise
);
   // ==========================================================
   // Storage.
   logic [STAGES-1:0] sync_chain; // Bit 0 is read only by bit 1.
   logic level_prev; // Previous chosen level, for edge detection.
   logic chosen_level; // Synchronised or raw level.

   // The raw path is used only when software asks for it; it skips the chain latency.
   assign chosen_level = i_bypass ? i_level : sync_chain[STAGES-1];

   // Shift the chain and remember the last level.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sync_chain <= '0;
         level_prev <= 1'b0;
         o_rise <= 1'b0;
      end else if (i_clock_en) begin
         sync_chain <= {sync_chain[STAGES-2:0], i_level};
         level_prev <= chosen_level;
         o_rise <= chosen_level & ~level_prev;
      end
   end
endmodule

// file: rtl/gst_timer.sv
// Gated sixteen-bit timer with clock selection, prescaler and gate logic.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module gst_timer
   import gst_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_clock_en,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_low_freq_internal_osc,
   input wire logic i_ext_clock_pin,
   input wire logic i_gate_pin,
   input wire logic i_timer0_rollover,
   input wire logic i_comparator1_output,
   input wire logic i_comparator2_output,
   output logic [15:0] o_count,
   output logic o_gate_level_status,
   output logic o_rollover_flag,
   output logic o_gate_event_flag
);
   // ==========================================================
   // Address decode helper, used by every register.
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = (adr[7:2] == off[7:2]);
   endfunction

   // ==========================================================
   // Declarations.
   logic [7:0] timer_control; // Writable control bits only.
   logic [7:0] gate_control; // Writable gate bits; armed and level are held apart.
   logic single_pulse_armed; // Armed bit, set by software, cleared by hardware.
   logic [15:0] count; // The counter itself.
   logic [1:0] div4_phase; // Divide-by-four phase counter.
   logic [2:0] pre_cnt; // Prescaler count.
   logic [2:0] pre_limit; // Last prescaler count for the chosen ratio.
   logic ext_rise; // Rising edge of the external clock pin.
   logic lfo_rise; // Rising edge of the low-frequency oscillator.
   logic src_tick; // One pulse per selected source clock edge.
   logic pre_tick; // One pulse per prescaled clock edge.
   logic gate_src; // Selected raw gate input.
   logic gate_pol; // Gate after polarity, high means count.
   logic gate_pol_q; // Previous polarity-adjusted gate.
   logic gate_rise; // Rising edge of the polarity-adjusted gate.
   logic toggle_ff; // Gate toggle flip-flop.
   logic gate_t; // Gate after the optional toggle stage.
   logic gate_t_q; // Previous toggled gate.
   gst_sp_state_t sp_state; // Single pulse window state.
   gst_sp_state_t next_sp_state; // Next single pulse window state.
   logic sp_start; // Window opens this cycle.
   logic sp_end; // Window closes this cycle.
   logic next_gate_level; // Gate value that the counter obeys next.
   logic gate_level_q; // Previous gate level, for the event flag.
   logic bus_req; // A bus cycle waits for its answer.
   logic wr_tc; // Write to the timer control register.
   logic wr_gc; // Write to the gate control register.
   logic wr_lo; // Write to the count low byte.
   logic wr_hi; // Write to the count high byte.
   logic wr_ef; // Write to the event flag register.
   logic cnt_wr; // Any write to the count.
   logic count_inc; // The counter steps this cycle.
   logic count_wrap; // The counter wraps this cycle.
   logic gate_fall; // Gate level falls this cycle.
   logic [7:0] rd_byte; // Read data before registering.

   // ==========================================================
   // Bus strobes. Only byte lane 0 carries register data.
   assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wr_tc = bus_req & i_wb_we & i_wb_sel[0] & hit(i_wb_adr, GST_OFF_TIMER_CONTROL);
   assign wr_gc = bus_req & i_wb_we & i_wb_sel[0] & hit(i_wb_adr, GST_OFF_GATE_CONTROL);
   assign wr_lo = bus_req & i_wb_we & i_wb_sel[0] & hit(i_wb_adr, GST_OFF_COUNT_LOW);
   assign wr_hi = bus_req & i_wb_we & i_wb_sel[0] & hit(i_wb_adr, GST_OFF_COUNT_HIGH);
   assign wr_ef = bus_req & i_wb_we & i_wb_sel[0] & hit(i_wb_adr, GST_OFF_EVENT_FLAGS);
   assign cnt_wr = wr_lo | wr_hi;

   // Control registers clear only on the power-on reset input; otherwise only bus writes change them.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         timer_control <= GST_RST_BYTE;
         gate_control <= GST_RST_BYTE;
      end else if (i_clock_en) begin
         if (wr_tc) begin
            timer_control <= i_wb_dat[7:0] & 8'hf5;
         end
         if (wr_gc) begin
            gate_control <= i_wb_dat[7:0] & 8'hf3;
         end
      end
   end

   // ==========================================================
   // Count clock sources.
   gst_edge_sync #(.STAGES(GST_SYNC_STAGES)) u_ext_sync (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_clock_en(i_clock_en),
      .i_level(i_ext_clock_pin),
      .i_bypass(timer_control[GST_TC_SYNC_BYPASS]),
      .o_rise(ext_rise)
   );

   // The oscillator is always synchronised; it is slow, so latency costs nothing.
   gst_edge_sync #(.STAGES(GST_SYNC_STAGES)) u_lfo_sync (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_clock_en(i_clock_en),
      .i_level(i_low_freq_internal_osc),
      .i_bypass(1'b0),
      .o_rise(lfo_rise)
   );

   // Free-running divide-by-four phase.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         div4_phase <= 2'h0;
      end else if (i_clock_en) begin
         div4_phase <= div4_phase + 2'h1;
      end
   end

   // Pick one tick per edge of the chosen source.
   always_comb begin
      unique case (timer_control[GST_TC_CS_LO +: 2])
         GST_CS_FOSC_DIV4: src_tick = (div4_phase == GST_DIV4_LAST);
         GST_CS_FOSC: src_tick = 1'b1;
         GST_CS_EXT_PIN: src_tick = ext_rise;
         GST_CS_LFOSC: src_tick = lfo_rise;
      endcase
   end

   // ==========================================================
   // Prescaler. A count write restarts it so the next step is a full period.
   assign pre_limit = (3'h1 << timer_control[GST_TC_PS_LO +: 2]) - 3'h1;
   assign pre_tick = src_tick & (pre_cnt == pre_limit);

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pre_cnt <= 3'h0;
      end else if (i_clock_en) begin
         if (cnt_wr || !timer_control[GST_TC_TIMER_ON]) begin
            pre_cnt <= 3'h0;
         end else if (pre_tick) begin
            pre_cnt <= 3'h0;
         end else if (src_tick) begin
            pre_cnt <= pre_cnt + 3'h1;
         end
      end
   end

   // ==========================================================
   // Gate source and polarity.
   always_comb begin
      unique case (gate_control[GST_GC_SS_LO +: 2])
         GST_GS_PIN: gate_src = i_gate_pin;
         GST_GS_TIMER0: gate_src = i_timer0_rollover;
         GST_GS_COMP1: gate_src = i_comparator1_output;
         GST_GS_COMP2: gate_src = i_comparator2_output;
      endcase
   end

   assign gate_pol = gate_control[GST_GC_POLARITY] ? gate_src : ~gate_src;
   assign gate_rise = gate_pol & ~gate_pol_q;

   // Toggle flop; held clear when toggle mode or the timer is off so the measured edge is known.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         gate_pol_q <= 1'b0;
         toggle_ff <= 1'b0;
      end else if (i_clock_en) begin
         gate_pol_q <= gate_pol;
         if (!timer_control[GST_TC_TIMER_ON] || !gate_control[GST_GC_TOGGLE]) begin
            toggle_ff <= 1'b0;
         end else if (gate_rise) begin
            toggle_ff <= ~toggle_ff;
         end
      end
   end

   assign gate_t = gate_control[GST_GC_TOGGLE] ? toggle_ff : gate_pol;

   // ==========================================================
   // Single pulse window: opens on a rising gate edge while armed, closes on the trailing edge.
   assign sp_start = gate_control[GST_GC_SINGLE_PULSE] & single_pulse_armed & (sp_state == GST_SP_CLOSED)
                     & gate_t & ~gate_t_q;
   assign sp_end = (sp_state == GST_SP_OPEN) & ~gate_t & gate_t_q;

   always_comb begin
      next_sp_state = sp_state;
      unique case (sp_state)
         GST_SP_CLOSED: begin
            if (sp_start) begin
               next_sp_state = GST_SP_OPEN;
            end
         end
         GST_SP_OPEN: begin
            if (sp_end || !gate_control[GST_GC_SINGLE_PULSE]) begin
               next_sp_state = GST_SP_CLOSED;
            end
         end
      endcase
   end

   // In single pulse mode the counter sees only the window, so later pulses are blocked.
   assign next_gate_level = gate_control[GST_GC_SINGLE_PULSE] ? (next_sp_state == GST_SP_OPEN) : gate_t;

   // Window state and armed bit; a software arm in the same cycle wins over the hardware clear.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         sp_state <= GST_SP_CLOSED;
         gate_t_q <= 1'b0;
         single_pulse_armed <= 1'b0;
      end else if (i_clock_en) begin
         sp_state <= next_sp_state;
         gate_t_q <= gate_t;
         if (wr_gc) begin
            single_pulse_armed <= i_wb_dat[GST_GC_ARMED] | (single_pulse_armed & ~sp_end);
         end else if (sp_end) begin
            single_pulse_armed <= 1'b0;
         end
      end
   end

   // Gate level status, shown whether or not gating is enabled.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_gate_level_status <= 1'b0;
         gate_level_q <= 1'b0;
      end else if (i_clock_en) begin
         o_gate_level_status <= next_gate_level;
         gate_level_q <= o_gate_level_status;
      end
   end

   // ==========================================================
   // Counter.
   assign count_inc = timer_control[GST_TC_TIMER_ON] & pre_tick
                      & (~gate_control[GST_GC_GATE_ENABLE] | o_gate_level_status);
   assign count_wrap = count_inc & ~cnt_wr & (count == GST_COUNT_MAX);
   assign gate_fall = gate_level_q & ~o_gate_level_status;

   // A software write wins over a step in the same cycle.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         count <= GST_RST_COUNT;
      end else if (i_clock_en) begin
         if (wr_lo) begin
            count[7:0] <= i_wb_dat[7:0];
         end
         if (wr_hi) begin
            count[15:8] <= i_wb_dat[7:0];
         end
         if (count_inc && !cnt_wr) begin
            count <= count + 16'h0001;
         end
      end
   end

   assign o_count = count;

   // Sticky flags, cleared by writing one; a new event in the clearing cycle keeps the flag set.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_rollover_flag <= 1'b0;
         o_gate_event_flag <= 1'b0;
      end else if (i_clock_en) begin
         o_rollover_flag <= count_wrap | (o_rollover_flag & ~(wr_ef & i_wb_dat[GST_EF_ROLLOVER]));
         o_gate_event_flag <= gate_fall | (o_gate_event_flag & ~(wr_ef & i_wb_dat[GST_EF_GATE_EVENT]));
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero and still get an answer.
   always_comb begin
      rd_byte = 8'h00;
      if (hit(i_wb_adr, GST_OFF_TIMER_CONTROL)) begin
         rd_byte = timer_control;
      end else if (hit(i_wb_adr, GST_OFF_GATE_CONTROL)) begin
         rd_byte = gate_control;
         rd_byte[GST_GC_ARMED] = single_pulse_armed;
         rd_byte[GST_GC_LEVEL] = o_gate_level_status;
      end else if (hit(i_wb_adr, GST_OFF_COUNT_LOW)) begin
         rd_byte = count[7:0];
      end else if (hit(i_wb_adr, GST_OFF_COUNT_HIGH)) begin
         rd_byte = count[15:8];
      end else if (hit(i_wb_adr, GST_OFF_EVENT_FLAGS)) begin
         rd_byte = {6'h00, o_gate_event_flag, o_rollover_flag};
      end
   end

   // Answer one cycle after the request; ack drops the cycle after it rises.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else if (i_clock_en) begin
         o_wb_ack <= bus_req;
         if (bus_req && !i_wb_we) begin
            o_wb_dat <= {24'h000000, rd_byte};
         end
      end
   end

   // ==========================================================
   // Checks.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst || !i_clock_en);

   fast_count_a: assert property ((timer_control[7:4] == 4'h4 && timer_control[0] && !gate_control[7] && !cnt_wr)
      |=> count == $past(count) + 16'h0001) else $error("count did not step on system clock");
   // A source change right after a tick may legally tick at once, so only ticks still in this mode count.
   div4_tick_a: assert property ((timer_control[7:6] == GST_CS_FOSC_DIV4 && src_tick)
      |=> (!src_tick || timer_control[7:6] != GST_CS_FOSC_DIV4) [*3])
      else $error("divide by four ticked too often");
   prescale_a: assert property (pre_tick |-> src_tick && pre_cnt == pre_limit) else $error("prescaler mistimed");
   off_hold_a: assert property ((!timer_control[0] && !cnt_wr) |=> $stable(count))
      else $error("count moved while off");
   toggle_clear_a: assert property ((!timer_control[0] || !gate_control[5]) |=> !toggle_ff)
      else $error("toggle flop not cleared");
   gate_hold_a: assert property ((timer_control[0] && gate_control[7] && !o_gate_level_status && !cnt_wr)
      |=> $stable(count)) else $error("count moved with gate closed");
   wrap_a: assert property (count_wrap |=> count == GST_RST_COUNT && o_rollover_flag)
      else $error("wrap did not clear count or set flag");
   gate_event_a: assert property ($fell(o_gate_level_status) |=> o_gate_event_flag)
      else $error("gate fall did not set flag");
   armed_clear_a: assert property ((sp_end && !wr_gc) |=> !single_pulse_armed && !o_gate_level_status)
      else $error("armed bit not cleared at pulse end");
   ctrl_zero_a: assert property ((bus_req && !i_wb_we && hit(i_wb_adr, GST_OFF_TIMER_CONTROL))
      |=> o_wb_ack && o_wb_dat[3] == 1'b0 && o_wb_dat[1] == 1'b0) else $error("unused bits read nonzero");
   ack_once_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");

   wrap_c: cover property (count_wrap);
   gate_event_c: cover property (gate_fall);
   pulse_done_c: cover property (sp_start ##[1:200] sp_end);
   toggle_c: cover property ($rose(toggle_ff));
endmodule

// file: sim/tb_gated_sixteen_bit_timer_ctrl.sv
// Self-checking testbench for the gated sixteen-bit timer control block.
`timescale 1ns/1ps
module tb_gated_sixteen_bit_timer_ctrl;
   import gst_pkg::*;
   // ==========================================================
   // Stimulus and observation signals.
   typedef struct {logic [7:0] tc; logic [7:0] gc; logic [3:0] g; logic [7:0] d;} gst_row_t;
   logic i_clock = 1'h0; // Bench clock, 25 ns period.
   logic i_srst = 1'h1; // Held high for the first ten cycles.
   logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, lvl, rf, gf;
   logic ce = 1'h1; // Clock enable, dropped once to check that the count freezes.
   logic [7:0] adr = 8'h00, rd;
   logic [31:0] dat = 32'h0, o_wb_dat;
   logic [3:0] gin = 4'h0; // Gate inputs: comparator 2, comparator 1, timer0, pin.
   logic [2:0] div = 3'h0; // Slow clocks run at one eighth of the bus clock.
   logic [15:0] cnt, held;
   int n_mismatch = 0, cmp_count = 0;
   logic [7:0] offs [5] = '{GST_OFF_TIMER_CONTROL, GST_OFF_GATE_CONTROL, GST_OFF_COUNT_LOW,
                            GST_OFF_COUNT_HIGH, GST_OFF_EVENT_FLAGS};
   // Each row counts for a fixed window; d is the clock divisor, zero meaning the count must hold.
   gst_row_t rows [18] = '{
      '{8'h41, 8'h00, 4'h0, 8'h01}, '{8'h01, 8'h00, 4'h0, 8'h04}, '{8'h81, 8'h00, 4'h0, 8'h08},
      '{8'h85, 8'h00, 4'h0, 8'h08}, '{8'hc1, 8'h00, 4'h0, 8'h08}, '{8'h51, 8'h00, 4'h0, 8'h02},
      '{8'h61, 8'h00, 4'h0, 8'h04}, '{8'h71, 8'h00, 4'h0, 8'h08}, '{8'h41, 8'hc0, 4'h0, 8'h00},
      '{8'h41, 8'hc0, 4'h1, 8'h01}, '{8'h41, 8'h80, 4'h0, 8'h01}, '{8'h41, 8'h40, 4'h0, 8'h01},
      '{8'h41, 8'hc1, 4'h2, 8'h01}, '{8'h41, 8'hc2, 4'h4, 8'h01}, '{8'h41, 8'hc3, 4'h4, 8'h00},
      '{8'h41, 8'hc3, 4'h8, 8'h01}, '{8'h41, 8'hc0, 4'he, 8'h00}, '{8'h40, 8'h00, 4'h0, 8'h00}};
   gst_timer gst_timer_i (.i_clock(i_clock), .i_srst(i_srst), .i_clock_en(ce), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(ack), .i_low_freq_internal_osc(div[2]), .i_ext_clock_pin(div[2]), .i_gate_pin(gin[0]),
      .i_timer0_rollover(gin[1]), .i_comparator1_output(gin[2]), .i_comparator2_output(gin[3]),
      .o_count(cnt), .o_gate_level_status(lvl), .o_rollover_flag(rf), .o_gate_event_flag(gf));
   // ==========================================================
   // Clock and slow clock generation.
   always #12.5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      div <= div + 3'h1;
   end
   // ==========================================================
   // Shared tasks.
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Counts within a tolerance, since bus overhead shifts the window edges by a cycle or two.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol, input string m);
      cmp_count++;
      if ($isunknown(got) || int'(got) > int'(exp) + tol || int'(got) + tol < int'(exp)) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Classic cycle: hold the request until ack is sampled high, then release for a cycle.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      do begin
         @(posedge i_clock);
         n++;
      end while (ack !== 1'h1 && n < 40);
      rd = o_wb_dat[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      if (n >= 40) begin
         chk(16'h0001, 16'h0000, 0, "bus timeout");
         test_done();
      end
   endtask
   // With polarity low and the gate pin low the gate is active, so the level status reads one.
   task automatic regs_zero();
      foreach (offs[i]) begin
         wb(1'h0, offs[i], 8'h00);
         chk({8'h00, rd}, (offs[i] == GST_OFF_GATE_CONTROL) ? 16'h0004 : 16'h0000, 0, "reset value");
      end
   endtask
   // The gate pin is held high for hi cycles, then low for four.
   task automatic pulse(input int hi);
      gin <= 4'h1;
      repeat (hi) @(posedge i_clock);
      gin <= 4'h0;
      repeat (4) @(posedge i_clock);
   endtask
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (10) @(posedge i_clock);
      i_srst <= 1'h0;
      regs_zero();
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'hff);
      wb(1'h0, GST_OFF_TIMER_CONTROL, 8'h00);
      chk({8'h00, rd}, 16'h00f5, 0, "timer control readback");
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h00);
      wb(1'h1, GST_OFF_GATE_CONTROL, 8'he7);
      wb(1'h0, GST_OFF_GATE_CONTROL, 8'h00);
      chk({8'h00, rd}, 16'h00e3, 0, "gate control readback");
      wb(1'h1, 8'h14, 8'hff);
      wb(1'h0, 8'h14, 8'h00);
      chk({8'h00, rd}, 16'h0000, 0, "unmapped read");
      wb(1'h1, GST_OFF_COUNT_LOW, 8'h34);
      wb(1'h1, GST_OFF_COUNT_HIGH, 8'h12);
      chk(cnt, 16'h1234, 0, "count bytes");
      $display("Test registers done");
      // Each row runs for a window of about 131 cycles between the two taken writes.
      foreach (rows[i]) begin
         wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h00);
         wb(1'h1, GST_OFF_COUNT_LOW, 8'h00);
         wb(1'h1, GST_OFF_COUNT_HIGH, 8'h00);
         wb(1'h1, GST_OFF_GATE_CONTROL, rows[i].gc);
         gin <= rows[i].g;
         wb(1'h1, GST_OFF_TIMER_CONTROL, rows[i].tc);
         repeat (128) @(posedge i_clock);
         wb(1'h1, GST_OFF_TIMER_CONTROL, rows[i].tc & 8'hfe);
         chk(cnt, rows[i].d == 8'h00 ? 16'h0 : 16'(131 / rows[i].d), rows[i].d == 8'h00 ? 0 : 2,
             "count after window");
      end
      $display("Test count table done");
      gin <= 4'h0;
      wb(1'h1, GST_OFF_GATE_CONTROL, 8'h00);
      wb(1'h1, GST_OFF_COUNT_LOW, 8'hff);
      wb(1'h1, GST_OFF_COUNT_HIGH, 8'hff);
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h41);
      repeat (8) @(posedge i_clock);
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h40);
      chk(cnt, 16'h000a, 2, "count after wrap");
      chk({15'h0, rf}, 16'h0001, 0, "rollover flag");
      $display("Test rollover done");
      // Gate enable is clear, yet the falling level must still raise the event flag.
      wb(1'h1, GST_OFF_GATE_CONTROL, 8'h40);
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h41);
      wb(1'h1, GST_OFF_EVENT_FLAGS, 8'h03);
      chk({14'h0, gf, rf}, 16'h0000, 0, "flags cleared");
      pulse(4);
      chk({15'h0, gf}, 16'h0001, 0, "gate event flag");
      wb(1'h1, GST_OFF_GATE_CONTROL, 8'he0);
      for (int k = 0; k < 3; k++) begin
         pulse(3);
         chk({15'h0, lvl}, {15'h0, ~k[0]}, 0, "toggle level");
      end
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h40);
      repeat (3) @(posedge i_clock);
      chk({15'h0, lvl}, 16'h0000, 0, "toggle cleared by off");
      $display("Test gate level done");
      wb(1'h1, GST_OFF_COUNT_LOW, 8'h00);
      wb(1'h1, GST_OFF_COUNT_HIGH, 8'h00);
      wb(1'h1, GST_OFF_GATE_CONTROL, 8'hd8);
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h41);
      wb(1'h0, GST_OFF_GATE_CONTROL, 8'h00);
      chk({8'h00, rd}, 16'h00d8, 0, "armed before pulse");
      pulse(10);
      chk(cnt, 16'h000a, 2, "single pulse count");
      wb(1'h0, GST_OFF_GATE_CONTROL, 8'h00);
      chk({8'h00, rd}, 16'h00d0, 0, "armed cleared");
      held = cnt;
      pulse(10);
      chk(cnt, held, 0, "second pulse blocked");
      $display("Test single pulse done");
      // Free counting, then the clock enable drops and the count must hold until it returns.
      wb(1'h1, GST_OFF_GATE_CONTROL, 8'h00);
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h41);
      ce <= 1'h0;
      @(posedge i_clock);
      held = cnt;
      repeat (20) @(posedge i_clock);
      chk(cnt, held, 0, "count frozen by clock enable");
      ce <= 1'h1;
      repeat (20) @(posedge i_clock);
      chk(cnt, held + 16'h0014, 2, "count resumes after clock enable");
      wb(1'h1, GST_OFF_TIMER_CONTROL, 8'h40);
      $display("Test clock enable done");
      // A second reset in mid-run must bring every register back to zero, except the gate level status bit, which reads one.
      i_srst <= 1'h1;
      repeat (10) @(posedge i_clock);
      i_srst <= 1'h0;
      regs_zero();
      $display("Test second reset done");
      test_done();
   end
endmodule
